// [rtl/radio_coexistence_arbiter_clock_ctrl.sv]
// radio core control register two: coexistence transaction, clock
// select, power-down permission, slow clock monitor, diagnostic pins
// assumes all inputs except the slow clock pin are on mclk
`timescale 1ns/10ps
`include "radio_coexistence_arbiter_cfg.svh"

module radio_coexistence_arbiter_clock_ctrl
  import radio_coexistence_arbiter_pkg::*;
#(
  parameter int       IRQ_N     = 32,
  parameter bit [3:0] LP_EDGES  = `LP_SEQ_EDGES
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [31:0]      reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output      logic [31:0]      reg_rdata,
  output      logic             irq,
  input  wire logic [9:0]       fine_slot_counter,
  input  wire logic             event_in_process,
  input  wire logic [3:0]       pti_static,
  input  wire logic [3:0]       pti_dynamic,
  input  wire logic             pti_valid,
  input  wire logic             txrx_en,
  output      coexistence_arbiter_out_t        coexistence_arbiter,
  input  wire logic             lp_clk_pin,
  input  wire logic             core_timer_reset,
  input  wire logic             deep_sleep_on,
  input  wire logic             sleep_exit_interrupt,
  input  wire logic             core_on_master_clk,
  input  wire logic [IRQ_N-1:0] cpu_irq_lines,
  input  wire logic             running_at_low_freq,
  input  wire logic             cpu_deep_sleep,
  input  wire logic             core_in_sleep,
  output      logic [5:0]       clk_mhz_sel,
  output      diag_pins_t       diag
);

  // --------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------
  if (IRQ_N < 1) begin : g_bad_irq
    $error("IRQ_N must be at least one");
  end
  if (LP_EDGES == 4'h0) begin : g_bad_edges
    $error("LP_EDGES must be nonzero");
  end

  // --------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------
  ctrl_t       ctrl;
  ctrl_t       next_ctrl;
  logic        mon;
  logic        next_mon;
  logic [1:0]  irq_stat;
  logic [1:0]  next_irq_stat;
  logic [1:0]  irq_en;
  logic [1:0]  next_irq_en;
  logic [31:0] next_rdata;
  logic        pd_ok;
  logic        lp_rise;
  logic        pd_set_evt;
  logic        wr_ctrl;

  assign wr_ctrl = reg_wr && (reg_addr == `CTRL_TWO_ADDR);

  // decode, sticky flags and read mux; a set always beats a clear
  always_comb begin
    next_ctrl     = ctrl;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;
    next_mon      = mon;
    next_rdata    = 32'h0000_0000;
    if (wr_ctrl) begin
      // test bits stored only, no effect on the logic
      next_ctrl.start      = reg_wdata[`F_START_LSB +: 10];
      next_ctrl.test_bit   = reg_wdata[`F_TEST_BIT];
      next_ctrl.iso_bit    = reg_wdata[`F_ISO_BIT];
      next_ctrl.pti_sel    = reg_wdata[`F_PTI_SEL];
      next_ctrl.pulse_mode = reg_wdata[`F_PULSE];
      next_ctrl.assert_src = reg_wdata[`F_SRC];
      // no guard against late changes: software's duty
      next_ctrl.clk_mhz    = reg_wdata[`F_CLK_LSB +: 6];
      next_ctrl.diag_sel   = reg_wdata[`F_DSEL_LSB +: 2];
      next_ctrl.diag_ovr   = reg_wdata[`F_OVR];
      if (!reg_wdata[`F_MON]) begin
        next_mon = 1'b0;  // only a zero clears
      end
    end else if (reg_wr && (reg_addr == `IRQ_CLR_ADDR)) begin
      next_irq_stat = irq_stat & ~reg_wdata[1:0];
    end else if (reg_wr && (reg_addr == `IRQ_EN_ADDR)) begin
      next_irq_en = reg_wdata[1:0];
    end
    if (lp_rise && !core_timer_reset) begin
      next_mon = 1'b1;
    end
    if (pd_set_evt) begin
      next_irq_stat[`IRQ_PD_OK] = 1'b1;
    end
    if (sleep_exit_interrupt) begin
      next_irq_stat[`IRQ_WAKE] = 1'b1;
    end
    if (reg_rd) begin
      if (reg_addr == `CTRL_TWO_ADDR) begin
        next_rdata[`F_START_LSB +: 10] = ctrl.start;
        next_rdata[`F_TEST_BIT]        = ctrl.test_bit;
        next_rdata[`F_ISO_BIT]         = ctrl.iso_bit;
        next_rdata[`F_PTI_SEL]         = ctrl.pti_sel;
        next_rdata[`F_PULSE]           = ctrl.pulse_mode;
        next_rdata[`F_SRC]             = ctrl.assert_src;
        next_rdata[`F_CLK_LSB +: 6]    = ctrl.clk_mhz;
        next_rdata[`F_PD_OK]           = pd_ok;
        next_rdata[`F_MON]             = mon;
        next_rdata[`F_CLK_STAT]        = core_on_master_clk;
        next_rdata[`F_DSEL_LSB +: 2]   = ctrl.diag_sel;
        next_rdata[`F_OVR]             = ctrl.diag_ovr;
      end else if (reg_addr == `IRQ_STAT_ADDR) begin
        next_rdata[1:0] = irq_stat;
      end else if (reg_addr == `IRQ_EN_ADDR) begin
        next_rdata[1:0] = irq_en;
      end
    end
  end

  // register the port state; read data live for one cycle only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl      <= `CTRL_RESET;
      mon       <= 1'b0;
      irq_stat  <= `IRQ_RESET;
      irq_en    <= `IRQ_RESET;
      reg_rdata <= 32'h0000_0000;
      irq       <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      mon       <= next_mon;
      irq_stat  <= next_irq_stat;
      irq_en    <= next_irq_en;
      reg_rdata <= next_rdata;
      irq       <= |(next_irq_stat & next_irq_en);
    end
  end

  assign clk_mhz_sel = ctrl.clk_mhz;

  // --------------------------------------------------------------------
  // slow clock sampling
  // --------------------------------------------------------------------
  logic lp_s1;
  logic lp_s2;
  logic lp_s3;
  logic lp_level;
  logic next_lp_level;

  // a level counts only when the last two stages agree
  always_comb begin
    next_lp_level = (lp_s2 == lp_s3) ? lp_s3 : lp_level;
  end

  assign lp_rise = (lp_s2 == lp_s3) && lp_s3 && !lp_level;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lp_s1    <= 1'b0;
      lp_s2    <= 1'b0;
      lp_s3    <= 1'b0;
      lp_level <= 1'b0;
    end else begin
      lp_s1    <= lp_clk_pin;
      lp_s2    <= lp_s1;
      lp_s3    <= lp_s2;
      lp_level <= next_lp_level;
    end
  end

  // --------------------------------------------------------------------
  // power-down permission sequence
  // --------------------------------------------------------------------
  pd_state_t pd_state;
  pd_state_t next_pd_state;
  logic [3:0] pd_cnt;
  logic [3:0] next_pd_cnt;

  // counts slow clock edges after the deep sleep request
  always_comb begin
    next_pd_state = pd_state;
    next_pd_cnt   = pd_cnt;
    case (pd_state)
      pd_idle: begin
        next_pd_cnt = 4'h0;
        if (deep_sleep_on) begin
          next_pd_state = pd_count;
        end
      end
      pd_count: begin
        if (sleep_exit_interrupt) begin
          next_pd_state = pd_idle;
        end else if (lp_rise) begin
          next_pd_cnt = pd_cnt + 4'h1;
          if (pd_cnt == LP_EDGES - 4'h1) begin
            next_pd_state = pd_allowed;
          end
        end
      end
      pd_allowed: begin
        if (sleep_exit_interrupt) begin
          next_pd_state = pd_idle;
        end
      end
      default: next_pd_state = pd_idle;
    endcase
  end

  assign pd_ok      = (pd_state == pd_allowed);
  assign pd_set_evt = (pd_state == pd_count) && (next_pd_state == pd_allowed);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pd_state <= pd_idle;
      pd_cnt   <= 4'h0;
    end else begin
      pd_state <= next_pd_state;
      pd_cnt   <= next_pd_cnt;
    end
  end

  // --------------------------------------------------------------------
  // coexistence transaction
  // --------------------------------------------------------------------
  tr_state_t  tr_state;
  tr_state_t  next_tr_state;
  logic [3:0] pti_sel_val;
  logic [3:0] pti_prev;
  logic       txrx_prev;
  logic       txrx_rise;
  logic       start_hit;
  logic       start_ok;
  logic       next_dip;

  assign pti_sel_val = ctrl.pti_sel ? pti_dynamic : pti_static;
  assign txrx_rise   = txrx_en && !txrx_prev;
  assign start_hit   = (fine_slot_counter == ctrl.start);
  // source bit picks which qualifier the start moment needs
  assign start_ok    = ctrl.assert_src ? event_in_process : pti_valid;

  always_comb begin
    next_tr_state = tr_state;
    case (tr_state)
      tr_idle: begin
        if (start_hit) begin
          next_tr_state = start_ok ? tr_active : tr_armed;
        end
      end
      tr_armed: begin
        // a stale arm would fire in the next event, so it dies with this one
        if (txrx_rise) begin
          next_tr_state = tr_active;
        end else if (!event_in_process) begin
          next_tr_state = tr_idle;
        end
      end
      tr_active: begin
        if (!event_in_process) begin
          next_tr_state = tr_idle;
        end
      end
      default: next_tr_state = tr_idle;
    endcase
    // one low cycle per priority change, only in pulse mode
    next_dip = ctrl.pulse_mode && (tr_state == tr_active) &&
               (next_tr_state == tr_active) && (pti_sel_val != pti_prev);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tr_state         <= tr_idle;
      pti_prev         <= 4'h0;
      txrx_prev        <= 1'b0;
      coexistence_arbiter.transaction <= 1'b0;
      coexistence_arbiter.prio        <= 4'h0;
    end else begin
      tr_state         <= next_tr_state;
      pti_prev         <= pti_sel_val;
      txrx_prev        <= txrx_en;
      coexistence_arbiter.transaction <= (next_tr_state == tr_active) && !next_dip;
      coexistence_arbiter.prio        <= pti_sel_val;
    end
  end

  // --------------------------------------------------------------------
  // diagnostic pin override
  // --------------------------------------------------------------------
  diag_pins_t next_diag;

  // pins stay released unless the override bit is set
  always_comb begin
    next_diag = '0;
    if (ctrl.diag_ovr) begin
      next_diag.out0     = |cpu_irq_lines;
      next_diag.oe0      = 1'b1;
      next_diag.oe1      = 1'b1;
      next_diag.latch_en = 1'b1;
      case (ctrl.diag_sel)
        2'h0:    next_diag.out1 = lp_level;
        2'h1:    next_diag.out1 = running_at_low_freq;
        2'h2:    next_diag.out1 = cpu_deep_sleep;
        default: next_diag.out1 = core_in_sleep;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      diag <= '0;
    end else begin
      diag <= next_diag;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  a_pti_dynamic: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ctrl.pti_sel |=> coexistence_arbiter.prio == $past(pti_dynamic))
    else $error("dynamic priority not forwarded");

  a_hold_steady: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !$past(ctrl.pulse_mode) && tr_state == tr_active |-> coexistence_arbiter.transaction)
    else $error("transaction dropped in steady mode");

  a_pulse_low: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ctrl.pulse_mode && tr_state == tr_active && event_in_process &&
    pti_sel_val != pti_prev |=> !coexistence_arbiter.transaction)
    else $error("no low cycle on priority change");

  a_pulse_back: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $fell(coexistence_arbiter.transaction) && tr_state == tr_active && event_in_process &&
    pti_sel_val == pti_prev |=> coexistence_arbiter.transaction)
    else $error("low period longer than one cycle");

  a_start_assert: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tr_state == tr_idle && start_hit && start_ok |=> coexistence_arbiter.transaction)
    else $error("transaction not raised at start match");

  a_armed_edge: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tr_state == tr_armed && txrx_rise |=> coexistence_arbiter.transaction)
    else $error("transaction not raised at enable edge");

  a_event_end: assert property (
    @(posedge mclk) disable iff (sys_rst)
    tr_state == tr_active && !event_in_process |=> !coexistence_arbiter.transaction ##1 !coexistence_arbiter.transaction)
    else $error("transaction held after event end");

  a_pd_raise: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(pd_ok) |-> $past(lp_rise) && $past(pd_state) == pd_count)
    else $error("permission raised without slow edge");

  a_pd_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    sleep_exit_interrupt |=> !pd_ok)
    else $error("permission kept after sleep exit");

  a_mon_set: assert property (
    @(posedge mclk) disable iff (sys_rst)
    lp_rise && !core_timer_reset |=> mon)
    else $error("monitor not set on slow edge");

  a_mon_blocked: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !mon && core_timer_reset |=> !mon)
    else $error("monitor set while timer in reset");

  a_clk_status: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_rd && reg_addr == `CTRL_TWO_ADDR |=>
    reg_rdata[`F_CLK_STAT] == $past(core_on_master_clk))
    else $error("clock status misread");

  a_diag_released: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !ctrl.diag_ovr |=> !diag.oe0 && !diag.oe1 && !diag.latch_en)
    else $error("pins driven without override");

  a_diag_or: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ctrl.diag_ovr |=> diag.latch_en && diag.out0 == $past(|cpu_irq_lines))
    else $error("first pin not interrupt OR");

  a_diag_sleep: assert property (
    @(posedge mclk) disable iff (sys_rst)
    ctrl.diag_ovr && ctrl.diag_sel == 2'h3 |=> diag.out1 == $past(core_in_sleep))
    else $error("second pin select wrong");

endmodule : radio_coexistence_arbiter_clock_ctrl

// [pkg/radio_coexistence_arbiter_cfg.svh]
// constants of the radio coexistence and clock control register block
// assumes one 25 MHz clock and a plain word-wide register port
//
// Summary of operation
// - priority source bit picks static or dynamic value
// - pulse mode clear holds transaction steady
// - pulse mode set: one low cycle per change
// - source clear: start needs priority, else enable edge
// - source set: start needs event, else enable edge
// - slow-clock sequence raises power-down permitted flag
// - sleep exit clears power-down permitted flag
// - slow clock edge sets monitor, software clears
// - no monitor setting while timer held in reset
// - clock status reads one on master clock
// - diagnostic select acts only under override
// - first pin carries OR of interrupts
// - second pin follows two-bit select
// - override forces latch enable and output direction
// - transaction asserted when fine counter matches start
// - transaction dropped when event ends
`ifndef RADIO_COEXISTENCE_ARBITER_CFG_SVH
`define RADIO_COEXISTENCE_ARBITER_CFG_SVH

// --------------------------------------------------------------------------
// register byte addresses
// --------------------------------------------------------------------------
`define CTRL_TWO_ADDR 32'h4000_0200
`define IRQ_STAT_ADDR 32'h4000_0240
`define IRQ_CLR_ADDR  32'h4000_0244
`define IRQ_EN_ADDR   32'h4000_0248

// --------------------------------------------------------------------------
// field positions of the control register
// --------------------------------------------------------------------------
`define F_START_LSB 22
`define F_TEST_BIT  19
`define F_ISO_BIT   18
`define F_PTI_SEL   17
`define F_PULSE     16
`define F_SRC       15
`define F_CLK_LSB   9
`define F_PD_OK     8
`define F_MON       7
`define F_CLK_STAT  6
`define F_DSEL_LSB  4
`define F_OVR       3

// interrupt status bits
`define IRQ_PD_OK 0
`define IRQ_WAKE  1

// --------------------------------------------------------------------------
// reset values and timing counts
// --------------------------------------------------------------------------
`define CTRL_RESET   24'h00_0000
`define IRQ_RESET    2'h0
`define LP_SEQ_EDGES 4'h3

`endif

// [pkg/radio_coexistence_arbiter_pkg.sv]
// types shared by the radio coexistence and clock control block
// assumes nothing beyond a SystemVerilog compiler
package radio_coexistence_arbiter_pkg;

  // software-written fields of the control register
  typedef struct packed {
    logic [9:0] start;
    logic       test_bit;
    logic       iso_bit;
    logic       pti_sel;
    logic       pulse_mode;
    logic       assert_src;
    logic [5:0] clk_mhz;
    logic [1:0] diag_sel;
    logic       diag_ovr;
  } ctrl_t;

  // what goes to the coexistence arbiter
  typedef struct packed {
    logic       transaction;
    logic [3:0] prio;
  } coexistence_arbiter_out_t;

  // the two diagnostic pins
  typedef struct packed {
    logic out0;
    logic oe0;
    logic out1;
    logic oe1;
    logic latch_en;
  } diag_pins_t;

  typedef enum logic [1:0] {tr_idle, tr_armed, tr_active} tr_state_t;
  typedef enum logic [1:0] {pd_idle, pd_count, pd_allowed} pd_state_t;

endpackage : radio_coexistence_arbiter_pkg

// [tb/coexistence_arbiter_side_model.sv]
// far side of the coexistence link: fine slot timing, radio enable pulses
// and a count of transaction rises seen by the arbiter
// assumes the bench pulses txrx_req for one mclk cycle
`timescale 1ns/10ps

module coexistence_arbiter_side_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       txrx_req,
  input  wire logic       transaction,
  output      logic [9:0] fine_slot_counter,
  output      logic       txrx_en,
  output      logic [7:0] tr_rises
);
  logic       tr_q;
  logic [1:0] en_cnt;

  // ------------------------------------------------------------------
  // slot timing
  // ------------------------------------------------------------------
  // free-running slot count; enable held two cycles so its rise is clean
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fine_slot_counter <= 10'h000;
      en_cnt            <= 2'h0;
      tr_q              <= 1'b0;
      tr_rises          <= 8'h00;
    end else begin
      fine_slot_counter <= fine_slot_counter + 10'h001;
      en_cnt            <= txrx_req ? 2'h2 : ((en_cnt != 2'h0) ? en_cnt - 2'h1 : 2'h0);
      tr_q              <= transaction;
      tr_rises          <= tr_rises + 8'((transaction && !tr_q) ? 1 : 0);
    end
  end

  assign txrx_en = (en_cnt != 2'h0); // low outside requested windows

endmodule : coexistence_arbiter_side_model

// [tb/testbench.sv]
// self-checking bench of the coexistence and clock control register block
// assumes the far-side model drives slot timing and radio enable
`timescale 1ns/10ps
`include "radio_coexistence_arbiter_cfg.svh"

module testbench;
  import radio_coexistence_arbiter_pkg::*;

  typedef struct packed {
    logic [1:0] sel;
    logic       lowf;
    logic       dslp;
    logic       insl;
    logic [3:0] irqs;
    logic       exp0;
    logic       exp1;
  } row_t;

  localparam int LPE = 3;
  localparam row_t ROWS [5] = '{
    '{2'h1, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1},
    '{2'h2, 1'b1, 1'b0, 1'b1, 4'h8, 1'b1, 1'b0},
    '{2'h3, 1'b1, 1'b1, 1'b0, 4'h1, 1'b1, 1'b0},
    '{2'h2, 1'b0, 1'b1, 1'b0, 4'h0, 1'b0, 1'b1},
    '{2'h0, 1'b0, 1'b0, 1'b0, 4'h2, 1'b1, 1'b1}};

  logic mclk, sys_rst, reg_wr, reg_rd, irq, event_in_process, pti_valid, txrx_en;
  logic lp_clk_pin, core_timer_reset, deep_sleep_on, sleep_exit_interrupt;
  logic core_on_master_clk, running_at_low_freq, cpu_deep_sleep, core_in_sleep;
  logic txrx_req;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [9:0]  fine_slot_counter;
  logic [3:0]  pti_static, pti_dynamic, cpu_irq_lines;
  logic [5:0]  clk_mhz_sel;
  logic [7:0]  tr_rises, r0;
  coexistence_arbiter_out_t   coexistence_arbiter;
  diag_pins_t  diag;
  int          n_errors, tests_run, lows;

  radio_coexistence_arbiter_clock_ctrl #(.IRQ_N(4), .LP_EDGES(4'(LPE))) DUT (.*);
  coexistence_arbiter_side_model PARTNER (.mclk(mclk), .sys_rst(sys_rst), .txrx_req(txrx_req),
    .transaction(coexistence_arbiter.transaction), .fine_slot_counter(fine_slot_counter),
    .txrx_en(txrx_en), .tr_rises(tr_rises));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [31:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    // taken at the edge that closes its only cycle, so stimulus stays on edges
    @(posedge mclk);
    d = reg_rdata;
  endtask : rd

  task ctrl(input logic [9:0] s, input logic sel, input logic pm, input logic src);
    wr(`CTRL_TWO_ADDR, {s, 4'h0, sel, pm, src, 15'h0000});
  endtask : ctrl

  // bounded waits; running out counts a mismatch and ends the run
  task wait_fine(input logic [9:0] v);
    for (int i = 0; i <= 1100; i++) begin
      @(posedge mclk);
      #1 if (fine_slot_counter === v) return;
    end
    check("slot wait", 32'h0, 32'h1);
    end_sim;
  endtask : wait_fine

  task wait_tr(input int lim);
    for (int i = 0; i <= lim; i++) begin
      @(posedge mclk);
      #1 if (coexistence_arbiter.transaction === 1'b1) return;
    end
    check("transaction wait", 32'h0, 32'h1);
    end_sim;
  endtask : wait_tr

  task lp_edges(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      lp_clk_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      lp_clk_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask : lp_edges

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, event_in_process, pti_valid, lp_clk_pin, txrx_req} = '0;
    {core_timer_reset, deep_sleep_on, sleep_exit_interrupt, core_on_master_clk} = '0;
    {running_at_low_freq, cpu_deep_sleep, core_in_sleep} = '0;
    {reg_addr, reg_wdata, pti_static, pti_dynamic, cpu_irq_lines} = '0;
    n_errors  = 0;
    tests_run = 0;
    sys_rst   = 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`CTRL_TWO_ADDR);
    check("ctrl reset", d, 32'h0);
    check("outputs reset", 32'({irq, coexistence_arbiter, diag}), 32'h0);
    // test bits stay zero, as software must keep them
    wr(`CTRL_TWO_ADDR, 32'hFFF3_FFFF);
    rd(`CTRL_TWO_ADDR);
    check("ctrl rw", d, 32'hFFC3_FE38);
    check("clk sel", 32'(clk_mhz_sel), 32'h3F);
    wr(`CTRL_TWO_ADDR, 32'h0000_2000);
    wr(32'h4000_0204, 32'hFFFF_FFFF);
    rd(`CTRL_TWO_ADDR);
    check("unmapped write", d, 32'h0000_2000);
    check("clk 16", 32'(clk_mhz_sel), 32'h10);
    rd(32'h4000_0204);
    check("unmapped read", d, 32'h0);
    rd(`IRQ_CLR_ADDR);
    check("clear reads 0", d, 32'h0);
    @(posedge mclk);
    core_on_master_clk <= 1'b1;
    lp_clk_pin         <= 1'b1;
    rd(`CTRL_TWO_ADDR);
    check("clk status", 32'(d[6]), 32'h1);
    check("no override", 32'({diag.oe0, diag.oe1, diag.latch_en}), 32'h0);
    // diagnostic table
    foreach (ROWS[i]) begin
      @(posedge mclk);
      {running_at_low_freq, cpu_deep_sleep, core_in_sleep} <= {ROWS[i].lowf,
        ROWS[i].dslp, ROWS[i].insl};
      cpu_irq_lines <= ROWS[i].irqs;
      wr(`CTRL_TWO_ADDR, {26'h0, ROWS[i].sel, 4'h8});
      repeat (2) @(posedge mclk);
      #1 check("pin0", 32'(diag.out0), 32'(ROWS[i].exp0));
      check("pin1", 32'(diag.out1), 32'(ROWS[i].exp1));
      check("pin drive", 32'({diag.oe0, diag.oe1, diag.latch_en}), 32'h7);
    end
    // slow clock monitor
    @(posedge mclk);
    lp_clk_pin       <= 1'b0;
    core_timer_reset <= 1'b1;
    wr(`CTRL_TWO_ADDR, 32'h0);
    lp_edges(2);
    rd(`CTRL_TWO_ADDR);
    check("mon in reset", 32'(d[7]), 32'h0);
    core_timer_reset <= 1'b0;
    lp_edges(1);
    rd(`CTRL_TWO_ADDR);
    check("mon set", 32'(d[7]), 32'h1);
    wr(`CTRL_TWO_ADDR, 32'h0);
    rd(`CTRL_TWO_ADDR);
    check("mon clear", 32'(d[7]), 32'h0);
    // power-down permission and interrupts
    wr(`IRQ_EN_ADDR, 32'h3);
    deep_sleep_on <= 1'b1;
    lp_edges(1);
    rd(`CTRL_TWO_ADDR);
    check("pd early", 32'(d[8]), 32'h0);
    lp_edges(LPE);
    rd(`CTRL_TWO_ADDR);
    check("pd allowed", 32'(d[8]), 32'h1);
    check("irq on", 32'(irq), 32'h1);
    deep_sleep_on        <= 1'b0;
    sleep_exit_interrupt <= 1'b1;
    @(posedge mclk);
    sleep_exit_interrupt <= 1'b0;
    rd(`CTRL_TWO_ADDR);
    check("pd cleared", 32'(d[8]), 32'h0);
    rd(`IRQ_STAT_ADDR);
    check("irq status", d, 32'h3);
    wr(`IRQ_EN_ADDR, 32'h0);
    repeat (2) @(posedge mclk);
    #1 check("irq masked", 32'(irq), 32'h0);
    wr(`IRQ_CLR_ADDR, 32'h3);
    wr(`IRQ_EN_ADDR, 32'h3);
    rd(`IRQ_STAT_ADDR);
    check("irq cleared", {d, 31'(irq)} == 63'h0 ? 32'h0 : 32'h1, 32'h0);
    // transaction at the start moment with priority available
    pti_static       <= 4'h5;
    pti_dynamic      <= 4'hA;
    pti_valid        <= 1'b1;
    event_in_process <= 1'b1;
    wait_fine(10'h3F0);
    ctrl(10'h040, 1'b0, 1'b0, 1'b0);
    wait_tr(1100);
    check("start match", 32'(fine_slot_counter), 32'h41);
    check("static prio", 32'(coexistence_arbiter.prio), 32'h5);
    @(posedge mclk);
    pti_static <= 4'h6;
    lows = 0;
    repeat (5) begin
      @(posedge mclk);
      #1 lows += int'(coexistence_arbiter.transaction === 1'b0);
    end
    check("steady", 32'(lows), 32'h0);
    ctrl(10'h040, 1'b0, 1'b1, 1'b0);
    repeat (2) @(posedge mclk);
    r0 = tr_rises;
    pti_static <= 4'h7;
    lows = 0;
    repeat (5) begin
      @(posedge mclk);
      #1 lows += int'(coexistence_arbiter.transaction === 1'b0);
    end
    check("one low", 32'(lows), 32'h1);
    check("rises", 32'(tr_rises), 32'(r0 + 8'h01));
    ctrl(10'h040, 1'b1, 1'b0, 1'b0);
    repeat (3) @(posedge mclk);
    #1 check("dynamic prio", 32'(coexistence_arbiter.prio), 32'hA);
    @(posedge mclk);
    event_in_process <= 1'b0;
    @(posedge mclk);
    #1 check("event end", 32'(coexistence_arbiter.transaction), 32'h0);
    // no priority at the start moment: waits for the radio enable
    @(posedge mclk);
    event_in_process <= 1'b1;
    pti_valid        <= 1'b0;
    wait_fine(10'h3F0);
    ctrl(10'h080, 1'b0, 1'b0, 1'b0);
    wait_fine(10'h083);
    check("armed", 32'(coexistence_arbiter.transaction), 32'h0);
    @(posedge mclk);
    txrx_req <= 1'b1;
    @(posedge mclk);
    txrx_req <= 1'b0;
    wait_tr(6);
    @(posedge mclk);
    event_in_process <= 1'b0;
    repeat (2) @(posedge mclk);
    event_in_process <= 1'b1;
    // event qualifier instead of priority
    wait_fine(10'h3F0);
    ctrl(10'h100, 1'b0, 1'b0, 1'b1);
    wait_tr(1100);
    check("event start", 32'(fine_slot_counter), 32'h101);
    @(posedge mclk);
    event_in_process <= 1'b0;
    wait_fine(10'h3F0);
    ctrl(10'h180, 1'b0, 1'b0, 1'b1);
    wait_fine(10'h183);
    check("no event", 32'(coexistence_arbiter.transaction), 32'h0);
    end_sim;
  end

endmodule : testbench
